//--- core/tiu_edge.sv
// Edge and level detector for one event or interrupt pin.
`timescale 1ns/100ps
`default_nettype none
module tiu_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	input wire logic pol,
	output logic hit,
	output logic endp,
	output logic lvl
);
	typedef struct packed {
		logic armed;
		logic prev;
	} tiu_edge_state_t;
	tiu_edge_state_t s_q, s_d;
	logic rise, fall;

	// The first sample after reset only arms the detector, so a pin high at reset is no edge.
	always_comb begin
		s_d = s_q;
		s_d.armed = 1'b1;
		s_d.prev = pin;
		rise = s_q.armed & pin & ~s_q.prev;
		fall = s_q.armed & ~pin & s_q.prev;
		hit = pol ? fall : rise;
		endp = pol ? rise : fall;
		lvl = pin ^ pol;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : tiu_edge
`default_nettype wire

//--- core/tiu_pkg.sv
// Shared constants and types of the timer and interrupt unit.
package tiu_pkg;
	localparam int APB_AW = 8;
	localparam logic [7:0] ADDR_PS = 8'hC0;
	localparam logic [7:0] ADDR_OP = 8'hC4;
	localparam logic [7:0] ADDR_REQ = 8'hC8;
	localparam logic [7:0] ADDR_EN = 8'hCC;
	localparam logic [7:0] ADDR_TMODE = 8'hD0;
	localparam logic [7:0] ADDR_EG = 8'hD4;
	localparam logic [7:0] ADDR_TMR = 8'hE0;
	localparam logic [7:0] ADDR_TMR_LAST = 8'hEC;
	localparam logic [7:0] PS_RST = 8'h04;
	localparam int PS_IFLAG = 2;
	localparam int OP_SET = 0;
	localparam int OP_CLR = 1;
	localparam int OP_BRK = 2;
	localparam int NREQ = 7;
	localparam int REQ_EXTA = 0;
	localparam int REQ_EXTB = 1;
	localparam int REQ_EVT = 2;
	localparam int REQ_TMR = 3;
	localparam int NPIN = 4;
	localparam int PIN_EXTA = 0;
	localparam int PIN_EXTB = 1;
	localparam int PIN_EVA = 2;
	localparam int PIN_EVB = 3;
	localparam int EG_W = 6;
	localparam int EG_EVSEL = 4;
	localparam int EG_PWSEL = 5;
	localparam int NTMR = 4;
	localparam int T1 = 0;
	localparam int T2 = 1;
	localparam int T3 = 2;
	localparam int T4 = 3;
	localparam int TM_W = 8;
	localparam int TM_SRC_LSB = 3;
	localparam int TM_RUN = 5;
	localparam logic [7:0] TMR_RST = 8'hFF;
	localparam logic [7:0] TMR_ZERO = 8'h00;
	localparam logic [5:0] DIV_LAST = 6'h3F;
	localparam logic [5:0] DIV_ONE = 6'h01;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	typedef enum logic [2:0] {
		MODE_TIMER = 3'b000,
		MODE_EVENT = 3'b001,
		MODE_PULSE = 3'b010,
		MODE_PWIDTH = 3'b011,
		MODE_PWM = 3'b100
	} tiu_mode_t;
	typedef enum logic [1:0] {
		SRC_DIV = 2'b00,
		SRC_SUB = 2'b01,
		SRC_CHAIN = 2'b10,
		SRC_PIN = 2'b11
	} tiu_src_t;
endpackage : tiu_pkg

//--- core/tiu_timer.sv
// One 8-bit reloading down counter.
`timescale 1ns/100ps
`default_nettype none
module tiu_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [7:0] load_val,
	input wire logic tick,
	input wire logic run,
	output logic [7:0] count,
	output logic uf
);
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] rel;
	} tiu_tmr_state_t;
	tiu_tmr_state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		uf = run & tick & (s_q.cnt == tiu_pkg::TMR_ZERO);
		if (load) begin
			s_d.cnt = load_val;
			s_d.rel = load_val;
		end else if (uf) begin
			s_d.cnt = s_q.rel;
		end else if (run & tick) begin
			s_d.cnt = s_q.cnt - 8'h01;
		end
		count = s_q.cnt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= {tiu_pkg::TMR_RST, tiu_pkg::TMR_RST};
		end else begin
			s_q <= s_d;
		end
	end
endmodule : tiu_timer
`default_nettype wire

//--- core/tiu_top.sv
// Interrupt acceptance control and four 8-bit timers behind an APB slave.
`timescale 1ns/100ps
`default_nettype none
module tiu_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tiu_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic isr_enter,
	output logic irq_out,
	output logic brk_out,
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	input wire logic event_pin_a,
	input wire logic event_pin_b,
	input wire logic sub_clock_pin,
	output logic timer_out_pin_a,
	output logic timer_out_pin_b
);
	typedef struct packed {
		logic [7:0] ps;
		logic software_break_op;
		logic [tiu_pkg::NREQ-1:0] req;
		logic [tiu_pkg::NREQ-1:0] en;
		logic [tiu_pkg::EG_W-1:0] eg;
		logic [31:0] tmode;
		logic [5:0] pre;
		logic sub_prev;
		logic [1:0] chain;
		logic out_a;
		logic out_b;
		logic [31:0] rdata;
	} tiu_top_state_t;

	tiu_top_state_t q, n;

	logic [tiu_pkg::NPIN-1:0] pins;
	logic [tiu_pkg::NPIN-1:0] hit;
	logic [tiu_pkg::NPIN-1:0] endp;
	logic [tiu_pkg::NPIN-1:0] lvl;
	logic [tiu_pkg::NTMR-1:0] tick;
	logic [tiu_pkg::NTMR-1:0] run;
	logic [tiu_pkg::NTMR-1:0] uf;
	logic [tiu_pkg::NTMR-1:0] load;
	logic [7:0] cnt [tiu_pkg::NTMR];
	logic [2:0] mode [tiu_pkg::NTMR];
	logic div_tick;
	logic sub_tick;
	logic pw_lvl;
	logic wr;
	logic setup;
	logic dec_ok;
	logic [31:0] rd_val;
	logic [tiu_pkg::NREQ-1:0] req_set;
	logic [tiu_pkg::NREQ-1:0] req_clr;

	// A mode is honoured only on the timers whose pins can carry it.
	function automatic logic mode_ok(input int idx, input logic [2:0] m);
		logic ok;
		ok = 1'b0;
		case (m)
			tiu_pkg::MODE_TIMER: begin
				ok = 1'b1;
			end
			tiu_pkg::MODE_EVENT: begin
				ok = (idx != tiu_pkg::T2);
			end
			tiu_pkg::MODE_PULSE: begin
				ok = (idx == tiu_pkg::T1) || (idx == tiu_pkg::T4);
			end
			tiu_pkg::MODE_PWIDTH: begin
				ok = (idx == tiu_pkg::T4);
			end
			tiu_pkg::MODE_PWM: begin
				ok = (idx == tiu_pkg::T3);
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction : mode_ok

	assign pins = {event_pin_b, event_pin_a, ext_irq_pin_b, ext_irq_pin_a};

	genvar g;
	generate
		for (g = 0; g < tiu_pkg::NPIN; g++) begin : g_pin
			tiu_edge u_edge (
				.pclk(pclk),
				.presetn(presetn),
				.pin(pins[g]),
				.pol(q.eg[g]),
				.hit(hit[g]),
				.endp(endp[g]),
				.lvl(lvl[g])
			);
		end
	endgenerate

	assign pw_lvl = q.eg[tiu_pkg::EG_PWSEL] ? lvl[tiu_pkg::PIN_EVB] : lvl[tiu_pkg::PIN_EVA];

	generate
		for (g = 0; g < tiu_pkg::NTMR; g++) begin : g_tmr
			logic [2:0] m_raw;
			logic [1:0] src;
			logic pin_tick;
			logic chain_tick;
			logic base;
			logic t_loc;
			assign m_raw = q.tmode[g*tiu_pkg::TM_W +: 3];
			assign src = q.tmode[g*tiu_pkg::TM_W+tiu_pkg::TM_SRC_LSB +: 2];
			assign run[g] = q.tmode[g*tiu_pkg::TM_W+tiu_pkg::TM_RUN];
			assign mode[g] = mode_ok(g, m_raw) ? m_raw : tiu_pkg::MODE_TIMER;
			if (g == tiu_pkg::T1) begin : g_p1
				assign pin_tick = hit[tiu_pkg::PIN_EVA];
			end else if (g == tiu_pkg::T2) begin : g_p2
				assign pin_tick = 1'b0;
			end else begin : g_p34
				assign pin_tick = hit[tiu_pkg::PIN_EVB];
			end
			if (g == tiu_pkg::T2) begin : g_c2
				assign chain_tick = q.chain[0];
			end else if (g == tiu_pkg::T4) begin : g_c4
				assign chain_tick = q.chain[1];
			end else begin : g_c13
				assign chain_tick = 1'b1;
			end
			always_comb begin
				case (src)
					tiu_pkg::SRC_DIV: begin
						base = div_tick;
					end
					tiu_pkg::SRC_SUB: begin
						base = sub_tick;
					end
					tiu_pkg::SRC_CHAIN: begin
						base = chain_tick;
					end
					default: begin
						base = pin_tick;
					end
				endcase
				if (mode[g] == tiu_pkg::MODE_EVENT) begin
					t_loc = pin_tick;
				end else if (mode[g] == tiu_pkg::MODE_PWIDTH) begin
					t_loc = base & pw_lvl;
				end else begin
					t_loc = base;
				end
			end
			// Each loop copy drives its own bit through one continuous assignment.
			assign tick[g] = t_loc;
			assign load[g] = wr && (paddr == tiu_pkg::ADDR_TMR + 8'(4*g));
			tiu_timer u_tmr (
				.pclk(pclk),
				.presetn(presetn),
				.load(load[g]),
				.load_val(pwdata[7:0]),
				.tick(tick[g]),
				.run(run[g]),
				.count(cnt[g]),
				.uf(uf[g])
			);
			assign req_set[tiu_pkg::REQ_TMR+g] = uf[g] |
				((g == tiu_pkg::T4) && (mode[g] == tiu_pkg::MODE_PWIDTH) && run[g] &&
				(q.eg[tiu_pkg::EG_PWSEL] ? endp[tiu_pkg::PIN_EVB] : endp[tiu_pkg::PIN_EVA]));
		end
	endgenerate

	// Event-pin interrupt follows the pin chosen in the edge select register.
	assign req_set[tiu_pkg::REQ_EXTA] = hit[tiu_pkg::PIN_EXTA];
	assign req_set[tiu_pkg::REQ_EXTB] = hit[tiu_pkg::PIN_EXTB];
	assign req_set[tiu_pkg::REQ_EVT] = q.eg[tiu_pkg::EG_EVSEL] ? hit[tiu_pkg::PIN_EVB] : hit[tiu_pkg::PIN_EVA];

	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign req_clr = (wr && paddr == tiu_pkg::ADDR_REQ) ? pwdata[tiu_pkg::NREQ-1:0] : '0;
	assign div_tick = (q.pre == tiu_pkg::DIV_LAST);
	assign sub_tick = sub_clock_pin & ~q.sub_prev;

	// Read decode; the timer window needs word alignment inside its range.
	always_comb begin
		rd_val = tiu_pkg::ZERO32;
		dec_ok = 1'b1;
		if (paddr == tiu_pkg::ADDR_PS) begin
			rd_val[7:0] = q.ps;
		end else if (paddr == tiu_pkg::ADDR_OP) begin
			rd_val = tiu_pkg::ZERO32;
		end else if (paddr == tiu_pkg::ADDR_REQ) begin
			rd_val[tiu_pkg::NREQ-1:0] = q.req;
		end else if (paddr == tiu_pkg::ADDR_EN) begin
			rd_val[tiu_pkg::NREQ-1:0] = q.en;
		end else if (paddr == tiu_pkg::ADDR_TMODE) begin
			rd_val = q.tmode;
		end else if (paddr == tiu_pkg::ADDR_EG) begin
			rd_val[tiu_pkg::EG_W-1:0] = q.eg;
		end else if (paddr >= tiu_pkg::ADDR_TMR && paddr <= tiu_pkg::ADDR_TMR_LAST && paddr[1:0] == 2'b00) begin
			rd_val[7:0] = cnt[paddr[3:2]];
		end else begin
			dec_ok = 1'b0;
		end
	end

	always_comb begin
		n = q;
		n.pre = div_tick ? '0 : q.pre + tiu_pkg::DIV_ONE;
		n.sub_prev = sub_clock_pin;
		n.chain = {uf[tiu_pkg::T3], uf[tiu_pkg::T1]};
		if (setup) begin
			n.rdata = rd_val;
		end
		if (wr && paddr == tiu_pkg::ADDR_PS) begin
			n.ps = pwdata[7:0];
		end
		if (wr && paddr == tiu_pkg::ADDR_EN) begin
			n.en = pwdata[tiu_pkg::NREQ-1:0];
		end
		if (wr && paddr == tiu_pkg::ADDR_EG) begin
			n.eg = pwdata[tiu_pkg::EG_W-1:0];
		end
		if (wr && paddr == tiu_pkg::ADDR_TMODE) begin
			n.tmode = pwdata;
		end
		if (wr && paddr == tiu_pkg::ADDR_OP && pwdata[tiu_pkg::OP_CLR]) begin
			n.ps[tiu_pkg::PS_IFLAG] = 1'b0;
		end
		if (wr && paddr == tiu_pkg::ADDR_OP && pwdata[tiu_pkg::OP_SET]) begin
			n.ps[tiu_pkg::PS_IFLAG] = 1'b1;
		end
		// Entry into a service routine wins over a clear in the same cycle.
		if (isr_enter) begin
			n.ps[tiu_pkg::PS_IFLAG] = 1'b1;
			n.software_break_op = 1'b0;
		end
		if (wr && paddr == tiu_pkg::ADDR_OP && pwdata[tiu_pkg::OP_BRK]) begin
			n.software_break_op = 1'b1;
		end
		// A request arriving with its own clear is kept.
		n.req = (q.req & ~req_clr) | req_set;
		if (mode[tiu_pkg::T1] == tiu_pkg::MODE_PULSE && run[tiu_pkg::T1]) begin
			n.out_a = q.out_a ^ uf[tiu_pkg::T1];
		end else begin
			n.out_a = 1'b1;
		end
		// Timer 3 sets the PWM period; the value held in timer 4 sets the high time.
		if (mode[tiu_pkg::T3] == tiu_pkg::MODE_PWM && run[tiu_pkg::T3]) begin
			n.out_b = (cnt[tiu_pkg::T3] < cnt[tiu_pkg::T4]);
		end else if (mode[tiu_pkg::T4] == tiu_pkg::MODE_PULSE && run[tiu_pkg::T4]) begin
			n.out_b = q.out_b ^ uf[tiu_pkg::T4];
		end else begin
			n.out_b = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.ps <= tiu_pkg::PS_RST;
			q.out_a <= 1'b1;
			q.out_b <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// The break request is never masked; all others wait for a clear mask.
	assign irq_out = (|(q.req & q.en)) & ~q.ps[tiu_pkg::PS_IFLAG];
	assign brk_out = q.software_break_op;
	assign prdata = q.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~dec_ok;
	assign timer_out_pin_a = q.out_a;
	assign timer_out_pin_b = q.out_b;
endmodule : tiu_top
`default_nettype wire

//--- tb/tiu_pins.sv
// Pulse source model for the event and interrupt pins.
`timescale 1ns/100ps
`default_nettype none
module tiu_pins (
	output logic [3:0] pin_q
);
	initial pin_q = 4'h0;
	// Pulses stay high for two cycles and low for at least two, three between pulses of one call, so that the edge detectors never miss one.
	task automatic pulse(input int idx, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge tiu_top_tb.pclk) pin_q[idx] <= 1'b1;
			repeat (2) @(posedge tiu_top_tb.pclk);
			pin_q[idx] <= 1'b0;
			repeat (2) @(posedge tiu_top_tb.pclk);
		end
	endtask : pulse
endmodule : tiu_pins
`default_nettype wire

//--- tb/tiu_top_chk.sv
// Port assertions for the timer and interrupt unit.
`timescale 1ns/100ps
`default_nettype none
module tiu_top_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tiu_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic isr_enter,
	input wire logic irq_out,
	input wire logic brk_out,
	input wire logic timer_out_pin_a,
	input wire logic timer_out_pin_b
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic opw;
	assign opw = psel && penable && pwrite && paddr == tiu_pkg::ADDR_OP;
	a_set_mask: assert property (opw && pwdata[0] |=> !irq_out [*2])
		else $error("irq after set op");
	a_isr_mask: assert property (isr_enter |=> !irq_out)
		else $error("irq after isr entry");
	a_brk_set: assert property (opw && pwdata[2] && !isr_enter |=> brk_out)
		else $error("break refused");
	a_brk_hold: assert property (brk_out && !isr_enter |=> brk_out)
		else $error("break lost");
	a_brk_clr: assert property (isr_enter && !(opw && pwdata[2]) |=> !brk_out)
		else $error("break not cleared");
	a_rest_high: assert property ($rose(presetn) |-> timer_out_pin_a && timer_out_pin_b)
		else $error("timer pins not high");
	a_ps_width: assert property (psel && penable && !pwrite && paddr == tiu_pkg::ADDR_PS |-> prdata[31:8] == 24'h0)
		else $error("status word too wide");
	a_eg_mapped: assert property (psel && penable && paddr == tiu_pkg::ADDR_EG |-> !pslverr)
		else $error("edge select unmapped");
endmodule : tiu_top_chk
bind tiu_top tiu_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .isr_enter(isr_enter), .irq_out(irq_out),
	.brk_out(brk_out), .timer_out_pin_a(timer_out_pin_a), .timer_out_pin_b(timer_out_pin_b));
`default_nettype wire

//--- tb/tiu_top_tb.sv
// Self-checking bench for the timer and interrupt unit.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t %0h %0h", $time, a, b); end end
module tiu_top_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic isr_enter = 1'b0;
	logic sub_clk = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq_out, brk_out, tpa, tpb, err;
	logic [3:0] pin;
	int error_cnt = 0;
	int n_checks = 0;
	always #25 pclk = ~pclk;
	always #2000 sub_clk = ~sub_clk;
	tiu_pins u_src (.pin_q(pin));
	tiu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .isr_enter(isr_enter),
		.irq_out(irq_out), .brk_out(brk_out), .ext_irq_pin_a(pin[0]), .ext_irq_pin_b(pin[1]),
		.event_pin_a(pin[2]), .event_pin_b(pin[3]), .sub_clock_pin(sub_clk), .timer_out_pin_a(tpa),
		.timer_out_pin_b(tpb));
	task automatic final_report();
		$display("errors %0d checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			error_cnt++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_sig(input int w, input logic v);
		int k;
		for (k = 0; k < 40 && (w ? tpa : irq_out) !== v; k++) @(posedge pclk);
		if (k == 40) begin
			error_cnt++;
			final_report();
		end
	endtask : wait_sig
	task automatic t_regs();
		apb(0, tiu_pkg::ADDR_PS, 0);
		`CHK(rd, {24'h0, tiu_pkg::PS_RST})
		apb(1, tiu_pkg::ADDR_OP, 32'h2);
		apb(0, tiu_pkg::ADDR_PS, 0);
		`CHK(rd, 32'h0)
		apb(1, tiu_pkg::ADDR_OP, 32'h1);
		apb(0, tiu_pkg::ADDR_PS, 0);
		`CHK(rd, 32'h4)
		apb(1, tiu_pkg::ADDR_EG, 32'h3F);
		apb(0, tiu_pkg::ADDR_EG, 0);
		`CHK({err, rd}, 33'h3F)
		apb(0, 8'hF0, 0);
		`CHK(err, 1'b1)
	endtask : t_regs
	task automatic t_ext();
		apb(1, tiu_pkg::ADDR_EG, 32'h0);
		apb(1, tiu_pkg::ADDR_REQ, 32'h7F);
		apb(1, tiu_pkg::ADDR_EN, 32'h1);
		apb(1, tiu_pkg::ADDR_OP, 32'h2);
		u_src.pulse(tiu_pkg::PIN_EXTA, 1);
		wait_sig(0, 1'b1);
		apb(1, tiu_pkg::ADDR_OP, 32'h1);
		@(negedge pclk);
		`CHK(irq_out, 1'b0)
		apb(1, tiu_pkg::ADDR_OP, 32'h6);
		@(negedge pclk);
		`CHK({irq_out, brk_out}, 2'h3)
		@(posedge pclk) isr_enter <= 1'b1;
		@(posedge pclk) isr_enter <= 1'b0;
		@(negedge pclk);
		`CHK({irq_out, brk_out}, 2'h0)
	endtask : t_ext
	task automatic t_evt();
		apb(1, tiu_pkg::ADDR_EG, 32'h18);
		apb(1, tiu_pkg::ADDR_REQ, 32'h7F);
		// An idle cycle stands in for the no-operation step before enabling.
		@(posedge pclk);
		apb(1, tiu_pkg::ADDR_EN, 32'h4);
		apb(1, tiu_pkg::ADDR_OP, 32'h2);
		u_src.pulse(tiu_pkg::PIN_EVA, 1);
		`CHK(irq_out, 1'b0)
		u_src.pulse(tiu_pkg::PIN_EVB, 1);
		wait_sig(0, 1'b1);
		apb(0, tiu_pkg::ADDR_REQ, 0);
		`CHK(rd[6:0], 7'h04)
	endtask : t_evt
	task automatic t_cnt();
		int tl[3] = '{0, 2, 3};
		int pl[3] = '{2, 3, 3};
		logic [7:0] a;
		apb(1, tiu_pkg::ADDR_OP, 32'h1);
		apb(1, tiu_pkg::ADDR_EG, 32'h0);
		apb(1, tiu_pkg::ADDR_EN, 32'h78);
		foreach (tl[i]) begin
			a = tiu_pkg::ADDR_TMR + 8'(4 * tl[i]);
			apb(1, tiu_pkg::ADDR_TMODE, 32'h19 << (8 * tl[i]));
			apb(1, a, 32'h2);
			apb(1, tiu_pkg::ADDR_REQ, 32'h7F);
			apb(1, tiu_pkg::ADDR_TMODE, 32'h39 << (8 * tl[i]));
			u_src.pulse(pl[i], 2);
			apb(0, a, 0);
			`CHK(rd, 32'h0)
			apb(1, tiu_pkg::ADDR_TMODE, 32'h19 << (8 * tl[i]));
			u_src.pulse(pl[i], 1);
			apb(0, a, 0);
			`CHK(rd, 32'h0)
			apb(1, tiu_pkg::ADDR_TMODE, 32'h39 << (8 * tl[i]));
			u_src.pulse(pl[i], 1);
			apb(0, tiu_pkg::ADDR_REQ, 0);
			`CHK(rd[3 + tl[i]], 1'b1)
		end
	endtask : t_cnt
	task automatic t_pulse();
		apb(1, tiu_pkg::ADDR_TMR, 32'h3);
		apb(1, tiu_pkg::ADDR_TMODE, 32'h32);
		wait_sig(1, 1'b0);
		apb(1, tiu_pkg::ADDR_TMODE, 32'h12);
		wait_sig(1, 1'b1);
		repeat (8) @(posedge pclk);
		`CHK({tpa, tpb}, 2'h3)
	endtask : t_pulse
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_ext();
		t_evt();
		t_cnt();
		t_pulse();
		final_report();
	end
endmodule : tiu_top_tb
`default_nettype wire
